// ---- core/bus_initiator.sv ----
`timescale 1ns/100ps
module bus_initiator (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  bus_cmd_if.initiator                       bus,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic [3:0]                    req_cmd,
  input  wire logic [63:0]                   req_addr,
  input  wire logic [bus_cmd_pkg::CNT_W-1:0] req_cnt,
  input  wire logic [3:0]                    req_be_n,
  input  wire logic                          req_wide,
  input  wire logic [63:0]                   req_data,
  output logic                               req_rejected
);
  import bus_cmd_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE = 3'b001,
    I_ADDR = 3'b010,
    I_DATA = 3'b100
  } ini_state_t;

  ini_state_t       state_r;
  logic [3:0]       cmd_r;
  logic [63:0]      addr_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0]       be_r;
  logic             wide_r;
  logic [63:0]      data_r;
  logic             bad_req;
  cmd_class_t       cls;
  logic [7:0]       wr_be;
  logic [2:0]       last_a;

  assign cls = cmd_class(req_cmd);
  // reserved and alias codes never leave the initiator; counts outside 1..4096 either
  assign bad_req = cls == CLS_NA || req_cmd == CMD_ALIAS_RD || req_cmd == CMD_ALIAS_WR
                   || req_cnt == '0 || req_cnt > CNT_W'(MAX_BYTES);
  assign req_ready = state_r == I_IDLE;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= I_IDLE;
    end else begin
      case (state_r)
        I_IDLE: if (req_valid && !bad_req) state_r <= I_ADDR;
        I_ADDR: state_r <= I_DATA;
        default: state_r <= I_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_rejected <= 1'b0;
    end else begin
      req_rejected <= req_valid && req_ready && bad_req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r  <= CMD_INTA;
      addr_r <= '0;
      cnt_r  <= '0;
      be_r   <= BE_NONE4;
      wide_r <= 1'b0;
      data_r <= '0;
    end else if (req_valid && req_ready && !bad_req) begin
      cmd_r  <= req_cmd;
      addr_r <= req_addr;
      data_r <= req_data;
      if (cls == CLS_DWORD) begin
        cnt_r  <= CNT_W'(4) - CNT_W'(req_addr[1:0]);
        wide_r <= 1'b0;
        be_r   <= req_be_n;
      end else begin
        cnt_r  <= req_cnt;
        wide_r <= req_wide;
        be_r   <= BE_NONE4;
      end
    end
  end

  // last byte offset within the first data phase
  assign last_a = 3'(addr_r[2:0] + 3'(cnt_r - CNT_W'(1)));

  always_comb begin
    wr_be = 8'h00;
    if (wide_r) begin
      if (addr_r[2]) wr_be[3:0] = BE_NONE4;
      wr_be[3:0] = wr_be[3:0] | (addr_r[2] ? 4'h0 : lead_mask(addr_r[1:0]));
      wr_be[7:4] = wr_be[7:4] | (addr_r[2] ? lead_mask(addr_r[1:0]) : 4'h0);
      if (addr_r[2]) wr_be[3:0] = wr_be[3:0] | lead_mask(addr_r[1:0]);
    end else begin
      wr_be[3:0] = lead_mask(addr_r[1:0]);
      wr_be[7:4] = BE_NONE4;
    end
    // short writes also switch off bytes past the last byte
    if (cnt_r < CNT_W'(8) && {1'b0, addr_r[2:0]} + 4'(cnt_r) <= 4'd8) begin
      // a narrow first phase only holds the dword that the start sits in
      if (wide_r ? !last_a[2] : last_a[2] == addr_r[2]) begin
        wr_be[3:0] = wr_be[3:0] | tail_mask(last_a[1:0]);
      end
      if (wide_r && last_a[2]) wr_be[7:4] = wr_be[7:4] | tail_mask(last_a[1:0]);
      if (wide_r && !last_a[2]) wr_be[7:4] = BE_NONE4;
    end
    // 32-bit target behind a 64-bit start at an upper dword
    if (wide_r && bus.target_is32 && addr_r[2]) wr_be[3:0] = wr_be[7:4];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.addr_valid <= 1'b0;
      bus.dual_addr  <= 1'b0;
      bus.cbe_lo_a1  <= BE_NONE4;
      bus.cbe_hi_a1  <= BE_NONE4;
      bus.cbe_lo_a2  <= BE_NONE4;
      bus.addr       <= '0;
      bus.attr_be_n  <= BE_NONE4;
      bus.byte_cnt   <= '0;
      bus.req64_n    <= 1'b1;
      bus.data_valid <= 1'b0;
      bus.data       <= '0;
      bus.dp_be_n    <= BE_NONE;
    end else begin
      bus.addr_valid <= state_r == I_ADDR;
      bus.data_valid <= state_r == I_DATA;
      if (state_r == I_ADDR) begin
        bus.dual_addr <= addr_r[63:32] != 32'h0000_0000;
        bus.cbe_lo_a1 <= (addr_r[63:32] != 32'h0000_0000) ? CMD_DUAL_ADDR : cmd_r;
        bus.cbe_hi_a1 <= cmd_r;
        bus.cbe_lo_a2 <= cmd_r;
        // no-address commands drive a stable zero
        bus.addr      <= (cmd_r == CMD_INTA || cmd_r == CMD_SPECIAL) ? '0 : addr_r;
        bus.attr_be_n <= be_r;
        bus.byte_cnt  <= cnt_r;
        bus.req64_n   <= !wide_r;
      end
      if (state_r == I_DATA) begin
        bus.data    <= data_r;
        bus.dp_be_n <= (cmd_r == CMD_MEM_WR) ? wr_be : BE_NONE;
      end else begin
        bus.dp_be_n <= BE_NONE;
      end
    end
  end
endmodule

// ---- core/bus_cmd_pkg.sv ----
package bus_cmd_pkg;
  localparam logic [3:0] CMD_INTA      = 4'h0;
  localparam logic [3:0] CMD_SPECIAL   = 4'h1;
  localparam logic [3:0] CMD_IO_RD     = 4'h2;
  localparam logic [3:0] CMD_IO_WR     = 4'h3;
  localparam logic [3:0] CMD_RSV_A     = 4'h4;
  localparam logic [3:0] CMD_RSV_B     = 4'h5;
  localparam logic [3:0] CMD_MEM_RD_DW = 4'h6;
  localparam logic [3:0] CMD_MEM_WR    = 4'h7;
  localparam logic [3:0] CMD_ALIAS_RD  = 4'h8;
  localparam logic [3:0] CMD_ALIAS_WR  = 4'h9;
  localparam logic [3:0] CMD_CFG_RD    = 4'hA;
  localparam logic [3:0] CMD_CFG_WR    = 4'hB;
  localparam logic [3:0] CMD_SPLIT_CPL = 4'hC;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
  localparam logic [3:0] CMD_BLK_RD    = 4'hE;
  localparam logic [3:0] CMD_BLK_WR    = 4'hF;
  localparam logic [7:0] BE_NONE       = 8'hFF;
  localparam logic [3:0] BE_NONE4      = 4'hF;
  localparam int         MAX_BYTES     = 4096;
  localparam int         CNT_W         = 13;
  localparam int         ADDR_W        = 64;

  typedef enum logic [3:0] {
    CLS_DWORD = 4'b0001,
    CLS_DP    = 4'b0010,
    CLS_NONE  = 4'b0100,
    CLS_NA    = 4'b1000
  } cmd_class_t;

  // length and byte enable usage class of a command
  function automatic cmd_class_t cmd_class(input logic [3:0] cmd);
    if (cmd == CMD_RSV_A || cmd == CMD_RSV_B || cmd == CMD_DUAL_ADDR) begin
      cmd_class = CLS_NA;
    end else if (cmd == CMD_MEM_WR) begin
      cmd_class = CLS_DP;
    end else if (cmd == CMD_ALIAS_RD || cmd == CMD_ALIAS_WR || cmd[3:2] == 2'b11) begin
      cmd_class = CLS_NONE;
    end else begin
      cmd_class = CLS_DWORD;
    end
  endfunction

  // low-true enables forced off below an unaligned start, per 4-byte nibble
  function automatic logic [3:0] lead_mask(input logic [1:0] a);
    lead_mask = 4'((4'h1 << a) - 4'h1);
  endfunction

  // low-true enables forced off above an unaligned last byte
  function automatic logic [3:0] tail_mask(input logic [1:0] a);
    tail_mask = 4'(~((4'h2 << a) - 4'h1));
  endfunction
endpackage

// ---- core/bus_cmd_if.sv ----
`timescale 1ns/100ps
interface bus_cmd_if;
  import bus_cmd_pkg::*;
  logic              addr_valid;
  logic              dual_addr;
  logic [3:0]        cbe_lo_a1;
  logic [3:0]        cbe_hi_a1;
  logic [3:0]        cbe_lo_a2;
  logic [63:0]       addr;
  logic [3:0]        attr_be_n;
  logic [CNT_W-1:0]  byte_cnt;
  logic              req64_n;
  logic              data_valid;
  logic [63:0]       data;
  logic [7:0]        dp_be_n;
  logic              devsel_n;
  logic              target_is32;

  modport initiator (
    output addr_valid, dual_addr, cbe_lo_a1, cbe_hi_a1, cbe_lo_a2, addr, attr_be_n,
           byte_cnt, req64_n, data_valid, data, dp_be_n,
    input  devsel_n, target_is32
  );
  modport target (
    input  addr_valid, dual_addr, cbe_lo_a1, cbe_hi_a1, cbe_lo_a2, addr, attr_be_n,
           byte_cnt, req64_n, data_valid, data, dp_be_n,
    output devsel_n, target_is32
  );
endinterface

// ---- core/bus_target.sv ----
`timescale 1ns/100ps
module bus_target #(
  parameter bit IS_32BIT = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  bus_cmd_if.target        bus,
  output logic             claim,
  output logic [3:0]       eff_cmd,
  output logic [63:0]      first_addr,
  output logic [63:0]      last_addr,
  output logic             wr_valid,
  output logic [63:0]      wr_data,
  output logic [7:0]       wr_strobe,
  output logic             dword_be_bad
);
  import bus_cmd_pkg::*;

  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_DATA = 2'b10
  } tgt_state_t;

  tgt_state_t       state_r;
  logic [3:0]       cmd_nxt;
  logic [3:0]       cmd_r;
  logic [63:0]      start_r;
  logic [CNT_W-1:0] left_r;
  cmd_class_t       cls;
  logic [1:0]       be_first;
  logic [7:0]       range_m;
  logic             be_ok;
  logic [63:0]      start_nxt;

  assign bus.target_is32 = IS_32BIT;
  // alias codes behave as the block commands
  assign cmd_nxt = (bus.cbe_lo_a2 == CMD_ALIAS_RD) ? CMD_BLK_RD :
                   (bus.cbe_lo_a2 == CMD_ALIAS_WR) ? CMD_BLK_WR : bus.cbe_lo_a2;
  assign cls = cmd_class(cmd_nxt);

  // first enabled byte from the enable pattern
  always_comb begin
    be_first = 2'd0;
    if (bus.attr_be_n[0]) be_first = 2'd1;
    if (bus.attr_be_n[1:0] == 2'b11) be_first = 2'd2;
    if (bus.attr_be_n[2:0] == 3'b111) be_first = 2'd3;
    be_ok = bus.attr_be_n == BE_NONE4 || be_first == bus.addr[1:0];
  end

  always_comb begin
    start_nxt = bus.addr;
    if (cmd_nxt == CMD_CFG_RD || cmd_nxt == CMD_CFG_WR) begin
      start_nxt = {bus.addr[63:2], 2'b00};
    end else if (cls == CLS_DWORD && bus.attr_be_n != BE_NONE4) begin
      start_nxt = {bus.addr[63:2], be_first};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= T_IDLE;
      claim        <= 1'b0;
      eff_cmd      <= CMD_INTA;
      cmd_r        <= CMD_INTA;
      start_r      <= '0;
      left_r       <= '0;
      first_addr   <= '0;
      last_addr    <= '0;
      dword_be_bad <= 1'b0;
    end else begin
      claim <= 1'b0;
      case (state_r)
        T_IDLE: begin
          // reserved codes leave every register untouched
          if (bus.addr_valid && cls != CLS_NA) begin
            state_r <= T_DATA;
            claim   <= 1'b1;
            eff_cmd <= cmd_nxt;
            cmd_r   <= cmd_nxt;
            dword_be_bad <= cls == CLS_DWORD && !be_ok &&
                            cmd_nxt != CMD_CFG_RD && cmd_nxt != CMD_CFG_WR &&
                            cmd_nxt != CMD_INTA && cmd_nxt != CMD_SPECIAL;
            if (cmd_nxt == CMD_INTA || cmd_nxt == CMD_SPECIAL) begin
              start_r    <= '0;
              first_addr <= '0;
              last_addr  <= '0;
              left_r     <= '0;
            end else if (cls == CLS_DWORD) begin
              start_r    <= start_nxt;
              first_addr <= start_nxt;
              last_addr  <= {bus.addr[63:2], 2'b11};
              left_r     <= CNT_W'(4) - CNT_W'(start_nxt[1:0]);
            end else begin
              start_r    <= start_nxt;
              first_addr <= start_nxt;
              last_addr  <= bus.addr + 64'(bus.byte_cnt) - 64'h1;
              left_r     <= bus.byte_cnt;
            end
          end
        end
        default: if (bus.data_valid) state_r <= T_IDLE;
      endcase
    end
  end

  // bytes of the first data phase inside start..end; a 32-bit target or narrow request moves them onto lanes 3:0
  always_comb begin
    range_m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) >= start_r[2:0] && 13'(i) < 13'(start_r[2:0]) + left_r) range_m[i] = 1'b1;
    end
    if (IS_32BIT || !bus.req64_n == 1'b0) begin
      range_m[3:0] = start_r[2] ? range_m[7:4] : range_m[3:0];
      range_m[7:4] = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_valid  <= 1'b0;
      wr_data   <= '0;
      wr_strobe <= 8'h00;
    end else begin
      wr_valid <= 1'b0;
      if (state_r == T_DATA && bus.data_valid) begin
        wr_data  <= bus.data;
        if (cmd_r == CMD_MEM_WR) begin
          wr_valid  <= 1'b1;
          wr_strobe <= range_m & ~bus.dp_be_n;
        end else if (cmd_r == CMD_BLK_WR) begin
          wr_valid  <= 1'b1;
          wr_strobe <= range_m;
        end else if (cmd_r == CMD_IO_WR || cmd_r == CMD_CFG_WR) begin
          wr_valid  <= 1'b1;
          wr_strobe <= IS_32BIT || !start_r[2]
                       ? {4'h0, ~bus.attr_be_n} : {~bus.attr_be_n, 4'h0};
        end
      end
    end
  end

  assign bus.devsel_n = !claim;
endmodule

// ---- verification/bus_cmd_properties.sv ----
`timescale 1ns/100ps
module bus_cmd_properties (
  input wire logic                          ref_clk,
  input wire logic                          rst_b,
  input wire logic                          addr_valid,
  input wire logic                          dual_addr,
  input wire logic [3:0]                    cbe_lo_a1,
  input wire logic [3:0]                    cbe_hi_a1,
  input wire logic [3:0]                    cbe_lo_a2,
  input wire logic [63:0]                   addr,
  input wire logic [bus_cmd_pkg::CNT_W-1:0] byte_cnt,
  input wire logic                          req64_n,
  input wire logic                          data_valid,
  input wire logic [7:0]                    dp_be_n,
  input wire logic                          devsel_n
);
  import bus_cmd_pkg::*;
  logic [3:0] cmd_w;
  assign cmd_w = dual_addr ? cbe_lo_a2 : cbe_lo_a1;
  // own mask so a shared slip in the package helper cannot hide
  function automatic logic [3:0] lead(input logic [1:0] a);
    lead = {1'b0, a == 2'h3, a[1], a != 2'h0};
  endfunction
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_no_rsv_cmd: assert property (addr_valid |-> !(cmd_w inside {4'h4, 4'h5, 4'h8, 4'h9,
    4'hD})) else $error("reserved command on bus");
  a_dual_marker: assert property (addr_valid && dual_addr |-> cbe_lo_a1 == CMD_DUAL_ADDR
    && (req64_n || cbe_hi_a1 == cbe_lo_a2)) else $error("dual address phases wrong");
  a_dword_narrow: assert property (addr_valid && cmd_w inside {4'h0, 4'h1, 4'h2, 4'h3,
    4'h6, 4'hA, 4'hB} |-> req64_n) else $error("wide request on dword command");
  a_dp_be_high: assert property (addr_valid && cmd_w != CMD_MEM_WR |=> data_valid
    && dp_be_n == BE_NONE) else $error("data enables not high");
  a_lead_lo_off: assert property (addr_valid && cmd_w == CMD_MEM_WR |=>
    (dp_be_n[3:0] & lead($past(addr[1:0]))) == lead($past(addr[1:0])))
    else $error("lower enables before start asserted");
  a_lead_hi_off: assert property (addr_valid && cmd_w == CMD_MEM_WR && !req64_n && addr[2]
    |=> (dp_be_n[7:4] & lead($past(addr[1:0]))) == lead($past(addr[1:0])))
    else $error("upper enables before start asserted");
  a_cnt_in_range: assert property (addr_valid && cmd_w inside {4'h7, 4'hC, 4'hE, 4'hF}
    |-> byte_cnt inside {[1:4096]}) else $error("burst count out of range");
  a_claim_next: assert property (addr_valid |=> !devsel_n) else $error("no claim");
  a_claim_only: assert property (!devsel_n |-> $past(addr_valid))
    else $error("claim without address phase");
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import bus_cmd_pkg::*;
  logic ref_clk, rst_b, req_valid, req_ready, req_wide, req_rejected;
  logic [3:0] req_cmd, req_be_n, eff_cmd, t2_eff, ec, ec2;
  logic [63:0] req_addr, req_data, first_addr, last_addr, fa, la, wr_data, wd;
  logic [CNT_W-1:0] req_cnt;
  logic claim, wr_valid, dword_be_bad, t2_claim, t2_bad, got_claim, got_rej, got2, bad2;
  logic rdy, db;
  logic [7:0] wr_strobe, ws, wr_strobe_c, ws_c;
  int miscompares, tests_run;
  logic [3:0] legal_c [11] = '{CMD_INTA, CMD_SPECIAL, CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD_DW,
    CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR, CMD_SPLIT_CPL, CMD_BLK_RD, CMD_BLK_WR};
  logic [3:0] bad_c [5] = '{CMD_RSV_A, CMD_RSV_B, CMD_ALIAS_RD, CMD_ALIAS_WR, CMD_DUAL_ADDR};
  bus_cmd_if bus_a ();
  bus_cmd_if bus_b ();
  bus_cmd_if bus_c ();
  bus_initiator bus_initiator_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus_a),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_cnt(req_cnt), .req_be_n(req_be_n), .req_wide(req_wide), .req_data(req_data),
    .req_rejected(req_rejected));
  bus_target #(.IS_32BIT(1'b0)) bus_target_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus(bus_a), .claim(claim), .eff_cmd(eff_cmd), .first_addr(first_addr),
    .last_addr(last_addr), .wr_valid(wr_valid), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .dword_be_bad(dword_be_bad));
  // second target faces the bench, which breaks initiator rules on purpose
  bus_target #(.IS_32BIT(1'b0)) bus_target_inst_b (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus(bus_b), .claim(t2_claim), .eff_cmd(t2_eff), .first_addr(), .last_addr(),
    .wr_valid(), .wr_data(), .wr_strobe(), .dword_be_bad(t2_bad));
  // third pair puts a 32-bit target behind the same requests
  bus_initiator bus_initiator_inst_c (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus_c),
    .req_valid(req_valid), .req_ready(), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_cnt(req_cnt), .req_be_n(req_be_n), .req_wide(req_wide), .req_data(req_data),
    .req_rejected());
  bus_target #(.IS_32BIT(1'b1)) bus_target_inst_c (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus(bus_c), .claim(), .eff_cmd(), .first_addr(), .last_addr(), .wr_valid(),
    .wr_data(), .wr_strobe(wr_strobe_c), .dword_be_bad());
  bus_cmd_properties bus_cmd_properties_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .addr_valid(bus_a.addr_valid), .dual_addr(bus_a.dual_addr),
    .cbe_lo_a1(bus_a.cbe_lo_a1), .cbe_hi_a1(bus_a.cbe_hi_a1), .cbe_lo_a2(bus_a.cbe_lo_a2),
    .addr(bus_a.addr), .byte_cnt(bus_a.byte_cnt), .req64_n(bus_a.req64_n),
    .data_valid(bus_a.data_valid), .dp_be_n(bus_a.dp_be_n), .devsel_n(bus_a.devsel_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_req(input logic [3:0] c, input logic [63:0] a, input logic [12:0] n,
                        input logic [3:0] be, input logic w);
    @(negedge ref_clk);
    rdy = req_ready;
    req_cmd = c;
    req_addr = a;
    req_cnt = n;
    req_be_n = be;
    req_wide = w;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    got_claim = 1'b0;
    // the refusal pulse stands only until the next rising edge
    got_rej = req_rejected === 1'b1;
    for (int k = 0; k < 8 && !got_claim && !got_rej; k++) begin
      @(posedge ref_clk);
      #1;
      if (claim === 1'b1) begin
        got_claim = 1'b1;
        fa = first_addr;
        la = last_addr;
        ec = eff_cmd;
        db = dword_be_bad;
      end
      if (req_rejected === 1'b1)
        got_rej = 1'b1;
    end
    if (!got_claim && !got_rej) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge ref_clk);
    #1;
    ws = wr_valid ? wr_strobe : 8'h00;
    ws_c = wr_strobe_c;
    wd = wr_data;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t2_send(input logic [3:0] c, input logic [3:0] be, input logic [1:0] lo);
    @(negedge ref_clk);
    bus_b.cbe_lo_a1 = c;
    bus_b.cbe_hi_a1 = c;
    bus_b.cbe_lo_a2 = c;
    bus_b.addr = {62'h0400, lo};
    bus_b.attr_be_n = be;
    bus_b.addr_valid = 1'b1;
    @(negedge ref_clk);
    // claim stands for the one cycle after the address phase
    got2 = t2_claim === 1'b1;
    ec2 = t2_eff;
    bad2 = t2_bad;
    bus_b.addr_valid = 1'b0;
    bus_b.data_valid = 1'b1;
    @(negedge ref_clk);
    bus_b.data_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    {miscompares, tests_run} = '0;
    {req_valid, req_wide, req_cmd, req_be_n, req_addr, req_data, req_cnt} = '0;
    req_data = 64'h0123_4567_89AB_CDEF;
    {bus_b.addr_valid, bus_b.dual_addr, bus_b.data_valid, bus_b.data} = '0;
    {bus_b.cbe_lo_a1, bus_b.cbe_hi_a1, bus_b.cbe_lo_a2, bus_b.addr} = '0;
    {bus_b.attr_be_n, bus_b.dp_be_n, bus_b.req64_n} = '1;
    bus_b.byte_cnt = 13'h0004;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (legal_c[i]) begin
      do_req(legal_c[i], 64'h0100, 13'h0004, 4'h0, 1'b1);
      chk({rdy, ec}, {1'b1, legal_c[i]});
    end
    $display("test decode done");
    foreach (bad_c[i]) begin
      do_req(bad_c[i], 64'h0100, 13'h0004, 4'h0, 1'b1);
      chk({got_rej, got_claim}, 2'b10);
    end
    do_req(CMD_BLK_RD, 64'h0010, 13'h0000, 4'hF, 1'b1);
    chk(got_rej, 1'b1);
    do_req(CMD_BLK_RD, 64'h0010, 13'h1001, 4'hF, 1'b1);
    chk(got_rej, 1'b1);
    do_req(CMD_BLK_RD, 64'h0010, 13'h1000, 4'hF, 1'b1);
    chk(la, 64'h100F);
    $display("test refuse done");
    do_req(CMD_IO_WR, 64'h1002, 13'h0004, 4'h3, 1'b0);
    chk({fa, la, db}, {64'h1002, 64'h1003, 1'b0});
    do_req(CMD_CFG_WR, 64'h2001, 13'h0004, 4'h0, 1'b0);
    chk({fa, la}, {64'h2000, 64'h2003});
    do_req(CMD_MEM_WR, 64'h0103, 13'h0003, 4'hF, 1'b1);
    chk({fa, la, ws}, {64'h0103, 64'h0105, 8'h38});
    do_req(CMD_MEM_WR, 64'h0105, 13'h0002, 4'hF, 1'b1);
    chk(ws, 8'h60);
    chk(ws_c, 8'h06);
    do_req(CMD_MEM_WR, 64'h0102, 13'h0004, 4'hF, 1'b0);
    chk(ws, 8'h0C);
    do_req(CMD_BLK_WR, 64'h0002, 13'h0004, 4'hF, 1'b1);
    chk({la, ws}, {64'h0005, 8'h3C});
    chk(wd, 64'h0123_4567_89AB_CDEF);
    do_req(CMD_MEM_RD_DW, 64'h1_0000_0004, 13'h0004, 4'h0, 1'b0);
    chk({fa, ec}, {64'h1_0000_0004, CMD_MEM_RD_DW});
    $display("test address done");
    t2_send(CMD_ALIAS_RD, 4'hF, 2'h0);
    chk({got2, ec2}, {1'b1, CMD_BLK_RD});
    t2_send(CMD_ALIAS_WR, 4'hF, 2'h0);
    chk({got2, ec2}, {1'b1, CMD_BLK_WR});
    t2_send(CMD_RSV_A, 4'h0, 2'h0);
    chk(got2, 1'b0);
    t2_send(CMD_RSV_B, 4'h0, 2'h0);
    chk(got2, 1'b0);
    for (int a = 0; a < 4; a++) begin
      t2_send(CMD_IO_RD, ~(4'h1 << a), 2'(a));
      chk(bad2, 1'b0);
      t2_send(CMD_IO_RD, 4'h1 << a, 2'(a));
      chk(bad2, 1'b1);
      t2_send(CMD_IO_RD, 4'hF, 2'(a));
      chk(bad2, 1'b0);
    end
    $display("test far end done");
    tally_and_finish();
  end
endmodule
